// [src/diag_code_pulse_serializer.sv]
// top: serialises the diagnostic frame onto the pulse output
`timescale 1ns/1ns
`default_nettype none
`include "diag_params.svh"
module diag_code_pulse_serializer #(
   parameter int CLK_HZ = `DIAG_CLK_HZ,
   parameter int BIT_MS = `DIAG_BIT_MS,
   // cycles per bit; shorten in simulation
   parameter int BIT_CYCLES = (CLK_HZ / 1000) * BIT_MS
) (
   // clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RSTN,
   // condition flags from the safety logic
   input  wire logic                  SUPPLY_FAULT,
   input  wire logic                  GENERAL_FAULT,
   input  wire logic                  EXPANSION_FAULT,
   input  wire logic                  SELECTOR_MOVED,
   input  wire logic                  CROSS_CH1,
   input  wire logic                  CROSS_CH2,
   input  wire logic                  CROSS_START,
   input  wire logic                  SYNC_ONE_MISSING,
   input  wire logic                  SYNC_LATE,
   input  wire logic                  SAFETY_IDLE,
   // pulse output and frame status
   output var  logic                  DIAG_PULSE_OUT,
   output var  logic                  FRAME_START,
   output var  diag_pkg::diag_code_t  CODE_SENT,
   output var  diag_pkg::code_class_t CLASS_SENT,
   output var  logic                  ACTIVE
);
   import diag_pkg::*;

   localparam int CW = $clog2(BIT_CYCLES + 1);
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
   localparam logic [3:0] LAST_BIT = 4'(`DIAG_FRAME_BITS - 1);

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_SEND
   } ser_state_t;

   logic [9:0] flags_raw;
   logic [9:0] flags;
   diag_code_t sel_code;
   code_class_t sel_class;
   logic sel_valid;
   logic [9:0] sel_frame;

   ser_state_t state;
   ser_state_t next_state;
   logic [CW-1:0] tick;
   logic [CW-1:0] next_tick;
   logic [3:0] bit_idx;
   logic [3:0] next_bit_idx;
   logic [9:0] shreg;
   logic [9:0] next_shreg;
   logic config_latched;
   logic next_config_latched;
   logic next_pulse;
   logic next_frame_start;
   diag_code_t next_code_sent;
   code_class_t next_class_sent;
   logic next_active;

   function automatic logic [9:0] build_frame(input diag_code_t c);
      build_frame = {`DIAG_MARKER, c};
   endfunction : build_frame

   // a call result cannot be sliced, so the frame gets a net of its own
   assign sel_frame = build_frame(sel_code);

   assign flags_raw = {SUPPLY_FAULT, GENERAL_FAULT, EXPANSION_FAULT, SELECTOR_MOVED,
                       CROSS_CH1, CROSS_CH2, CROSS_START, SYNC_ONE_MISSING,
                       SYNC_LATE, SAFETY_IDLE};

   // pin inputs cross into the clock domain
   diag_sync #(
      .WIDTH(10)
   ) u_sync (
      .clk     (CLK),
      .rstn    (RSTN),
      .async_in(flags_raw),
      .sync_out(flags)
   );

   diag_code_select u_sel (
      .supply_fault    (flags[9]),
      .general_fault   (flags[8]),
      .expansion_fault (flags[7]),
      .config_fault    (config_latched),
      .cross_ch1       (flags[5]),
      .cross_ch2       (flags[4]),
      .cross_start     (flags[3]),
      .sync_one_missing(flags[2]),
      .sync_late       (flags[1]),
      .safety_idle     (flags[0]),
      .code            (sel_code),
      .code_class      (sel_class),
      .code_valid      (sel_valid)
   );

   always_comb begin
      next_state          = state;
      next_tick           = tick;
      next_bit_idx        = bit_idx;
      next_shreg          = shreg;
      next_pulse          = DIAG_PULSE_OUT;
      next_frame_start    = 1'b0;
      next_code_sent      = CODE_SENT;
      next_class_sent     = CLASS_SENT;
      next_active         = ACTIVE;
      // configuration error stays until reset
      next_config_latched = config_latched | flags[6];
      unique case (state)
         ST_IDLE: begin
            next_pulse  = 1'b0;
            next_active = 1'b0;
            if (sel_valid) begin
               next_state       = ST_SEND;
               next_shreg       = {sel_frame[8:0], 1'b0};
               next_pulse       = sel_frame[9];
               next_tick        = '0;
               next_bit_idx     = '0;
               next_frame_start = 1'b1;
               next_code_sent   = sel_code;
               next_class_sent  = sel_class;
               next_active      = 1'b1;
            end
         end
         ST_SEND: begin
            if (tick == BIT_LAST) begin
               next_tick = '0;
               if (bit_idx == LAST_BIT) begin
                  // code sampled only here and in ST_IDLE, so a frame is never torn
                  if (sel_valid) begin
                     next_shreg       = {sel_frame[8:0], 1'b0};
                     next_pulse       = sel_frame[9];
                     next_bit_idx     = '0;
                     next_frame_start = 1'b1;
                     next_code_sent   = sel_code;
                     next_class_sent  = sel_class;
                  end else begin
                     next_state  = ST_IDLE;
                     next_pulse  = 1'b0;
                     next_active = 1'b0;
                  end
               end else begin
                  next_bit_idx = bit_idx + 4'h1;
                  next_pulse   = shreg[9];
                  next_shreg   = {shreg[8:0], 1'b0};
               end
            end else begin
               next_tick = tick + CW'(1);
            end
         end
      endcase
      if (!RSTN) begin
         next_state          = ST_IDLE;
         next_tick           = '0;
         next_bit_idx        = '0;
         next_shreg          = '0;
         next_pulse          = 1'b0;
         next_frame_start    = 1'b0;
         next_code_sent      = '0;
         next_class_sent     = CLASS_STATUS;
         next_active         = 1'b0;
         next_config_latched = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      state          <= next_state;
      tick           <= next_tick;
      bit_idx        <= next_bit_idx;
      shreg          <= next_shreg;
      DIAG_PULSE_OUT <= next_pulse;
      FRAME_START    <= next_frame_start;
      CODE_SENT      <= next_code_sent;
      CLASS_SENT     <= next_class_sent;
      ACTIVE         <= next_active;
      config_latched <= next_config_latched;
   end
endmodule : diag_code_pulse_serializer
`default_nettype wire

// [src/diag_code_select.sv]
// picks the six-bit code and its class from the condition flags
`timescale 1ns/1ns
`default_nettype none
`include "diag_params.svh"
module diag_code_select (
   // condition flags, synchronised
   input  wire logic                 supply_fault,
   input  wire logic                 general_fault,
   input  wire logic                 expansion_fault,
   input  wire logic                 config_fault,
   input  wire logic                 cross_ch1,
   input  wire logic                 cross_ch2,
   input  wire logic                 cross_start,
   input  wire logic                 sync_one_missing,
   input  wire logic                 sync_late,
   input  wire logic                 safety_idle,
   // chosen code
   output var  diag_pkg::diag_code_t code,
   output var  diag_pkg::code_class_t code_class,
   output var  logic                 code_valid
);
   import diag_pkg::*;

   // errors outrank alerts, alerts outrank status
   always_comb begin
      code       = '0;
      code_class = CLASS_STATUS;
      code_valid = 1'b1;
      if (supply_fault) begin
         code       = `DIAG_CODE_SUPPLY;
         code_class = CLASS_ERROR;
      end else if (general_fault) begin
         code       = `DIAG_CODE_GEN;
         code_class = CLASS_ERROR;
      end else if (expansion_fault) begin
         code       = `DIAG_CODE_GEN_EXP;
         code_class = CLASS_ERROR;
      end else if (config_fault) begin
         code       = `DIAG_CODE_CONFIG;
         code_class = CLASS_ERROR;
      end else if (cross_ch1) begin
         code       = `DIAG_CODE_XC_CH1;
         code_class = CLASS_ERROR;
      end else if (cross_ch2) begin
         code       = `DIAG_CODE_XC_CH2;
         code_class = CLASS_ERROR;
      end else if (cross_start) begin
         code       = `DIAG_CODE_XC_START;
         code_class = CLASS_ERROR;
      end else if (sync_one_missing) begin
         code       = `DIAG_CODE_SYNC_ONE;
         code_class = CLASS_ALERT;
      end else if (sync_late) begin
         code       = `DIAG_CODE_SYNC_LATE;
         code_class = CLASS_ALERT;
      end else if (safety_idle) begin
         code       = `DIAG_CODE_IDLE;
         code_class = CLASS_STATUS;
      end else begin
         code_valid = 1'b0;
      end
   end
endmodule : diag_code_select
`default_nettype wire

// [src/diag_params.svh]
// constants for the diagnostic pulse serializer
`ifndef DIAG_PARAMS_SVH
`define DIAG_PARAMS_SVH

`define DIAG_CLK_HZ        20000000
`define DIAG_BIT_MS        200
`define DIAG_FRAME_BITS    10
`define DIAG_CODE_BITS     6
`define DIAG_MARKER        4'b0010
`define DIAG_CODE_SUPPLY   6'b101101
`define DIAG_CODE_GEN      6'b000011
`define DIAG_CODE_GEN_EXP  6'b000110
`define DIAG_CODE_CONFIG   6'b000111
`define DIAG_CODE_XC_CH1   6'b001100
`define DIAG_CODE_XC_CH2   6'b001111
`define DIAG_CODE_XC_START 6'b110000
`define DIAG_CODE_SYNC_ONE 6'b110011
`define DIAG_CODE_SYNC_LATE 6'b100111
`define DIAG_CODE_IDLE     6'b110111

`endif

// [src/diag_pkg.sv]
// types for the diagnostic pulse serializer
package diag_pkg;
   typedef enum logic [1:0] {
      CLASS_STATUS,
      CLASS_ALERT,
      CLASS_ERROR
   } code_class_t;
   typedef logic [5:0] diag_code_t;
endpackage : diag_pkg

// [src/diag_sync.sv]
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
`default_nettype none
module diag_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   always_comb begin
      next_stage1   = rstn ? async_in : '0;
      next_sync_out = rstn ? stage1 : '0;
   end

   always_ff @(posedge clk) begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
   end
endmodule : diag_sync
`default_nettype wire

// [test/diag_code_pulse_serializer_checker.sv]
// assertions on the pulse serializer ports
`timescale 1ns/1ns
`default_nettype none
module diag_code_pulse_serializer_checker #(
   parameter int BIT_CYCLES = 8
) (
   // clock, reset, flags
   input  wire logic                  CLK,
   input  wire logic                  RSTN,
   input  wire logic                  SUPPLY_FAULT,
   input  wire logic                  SAFETY_IDLE,
   // outputs
   input  wire logic                  DIAG_PULSE_OUT,
   input  wire logic                  FRAME_START,
   input  wire diag_pkg::diag_code_t  CODE_SENT,
   input  wire diag_pkg::code_class_t CLASS_SENT,
   input  wire logic                  ACTIVE
);
   import diag_pkg::*;
   localparam int FRAME = 10 * BIT_CYCLES;
   int          cnt;
   int          next_cnt;
   int          pos;
   code_class_t want_class;
   // saturating, so long idle gaps cost nothing
   always_comb begin
      next_cnt = (cnt < FRAME + 2) ? cnt + 1 : cnt;
      if (FRAME_START) next_cnt = 1;
      if (!RSTN) next_cnt = FRAME + 2;
      pos = FRAME_START ? 0 : cnt;
      want_class = CLASS_ERROR;
      if (CODE_SENT == 6'h37) want_class = CLASS_STATUS;
      if (CODE_SENT == 6'h33 || CODE_SENT == 6'h27) want_class = CLASS_ALERT;
   end
   always_ff @(posedge CLK) cnt <= next_cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_marker_bits: assert property (
      ACTIVE && pos < 4 * BIT_CYCLES |-> DIAG_PULSE_OUT == (pos / BIT_CYCLES == 2))
      else $error("marker bit wrong");
   a_code_bits: assert property (
      ACTIVE && pos >= 4 * BIT_CYCLES && pos < FRAME
      |-> DIAG_PULSE_OUT == CODE_SENT[9 - pos / BIT_CYCLES])
      else $error("code bit wrong");
   a_frame_spacing: assert property (
      FRAME_START && $past(ACTIVE) |-> cnt == FRAME)
      else $error("frame length wrong");
   a_frame_ends: assert property (
      cnt == FRAME && !FRAME_START |-> !ACTIVE)
      else $error("frame overran");
   a_code_held: assert property (
      ACTIVE && !FRAME_START |-> $stable(CODE_SENT))
      else $error("code changed mid-frame");
   a_class_map: assert property (
      ACTIVE |-> CLASS_SENT == want_class)
      else $error("class wrong");
   a_supply_code: assert property (
      FRAME_START && $past(SUPPLY_FAULT, 2) && $past(SUPPLY_FAULT, 3)
      && $past(SUPPLY_FAULT, 4) |-> CODE_SENT == 6'h2d)
      else $error("supply code wrong");
   a_idle_quiet: assert property (
      !ACTIVE |-> !DIAG_PULSE_OUT && !FRAME_START)
      else $error("output moved while idle");
   a_idle_starts: assert property (
      !ACTIVE && SAFETY_IDLE |-> ##[1:4] ACTIVE)
      else $error("status frame not started");
endmodule : diag_code_pulse_serializer_checker

bind diag_code_pulse_serializer diag_code_pulse_serializer_checker #(
   .BIT_CYCLES(BIT_CYCLES)
) u_diag_code_pulse_serializer_checker (
   .CLK(CLK), .RSTN(RSTN), .SUPPLY_FAULT(SUPPLY_FAULT), .SAFETY_IDLE(SAFETY_IDLE),
   .DIAG_PULSE_OUT(DIAG_PULSE_OUT), .FRAME_START(FRAME_START), .CODE_SENT(CODE_SENT),
   .CLASS_SENT(CLASS_SENT), .ACTIVE(ACTIVE)
);
`default_nettype wire

// [test/diag_monitor.sv]
// far-side monitor: reads the pulse line and assembles frames
`timescale 1ns/1ns
`default_nettype none
module diag_monitor #(
   parameter int BIT = 8
) (
   // clock and line
   input  wire logic       clk,
   input  wire logic       line,
   input  wire logic       start,
   // received frame
   output var  logic [9:0] frame,
   output var  logic       done
);
   int         c = 0;
   int         nb = 0;
   logic       run = 1'b0;
   logic [9:0] sh = '0;
   // mid-bit sampling, away from both transitions
   always @(posedge clk) begin
      done <= 1'b0;
      if (start) begin
         c   <= 1;
         nb  <= 0;
         run <= 1'b1;
      end else if (run) begin
         c <= c + 1;
         if (c % BIT == BIT / 2) begin
            sh <= {sh[8:0], line};
            nb <= nb + 1;
            if (nb == 9) begin
               frame <= {sh[8:0], line};
               done  <= 1'b1;
               run   <= 1'b0;
            end
         end
      end
   end
endmodule : diag_monitor
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the pulse serializer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import diag_pkg::*;
   localparam int BIT = 8;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [9:0]  fl = '0;
   logic        pulse, fs, active, done;
   logic [9:0]  frame, want;
   logic [9:0]  rnd;
   logic [9:0]  exp_q[$];
   int          failures = 0;
   int          n_checks = 0;
   int          seed = 32'h099b;
   int          cur = 9;
   int          i;
   // whole frames by priority slot, highest first
   logic [9:0]  tbl [10] = '{10'h0ad, 10'h083, 10'h086, 10'h087, 10'h08c,
                             10'h08f, 10'h0b0, 10'h0b3, 10'h0a7, 10'h0b7};
   always #25 clk = ~clk;
   diag_code_pulse_serializer #(.BIT_CYCLES(BIT)) u_diag_code_pulse_serializer (
      .CLK(clk), .RSTN(rstn), .SUPPLY_FAULT(fl[0]), .GENERAL_FAULT(fl[1]),
      .EXPANSION_FAULT(fl[2]), .SELECTOR_MOVED(fl[3]), .CROSS_CH1(fl[4]),
      .CROSS_CH2(fl[5]), .CROSS_START(fl[6]), .SYNC_ONE_MISSING(fl[7]),
      .SYNC_LATE(fl[8]), .SAFETY_IDLE(fl[9]), .DIAG_PULSE_OUT(pulse),
      .FRAME_START(fs), .CODE_SENT(), .CLASS_SENT(), .ACTIVE(active));
   diag_monitor #(.BIT(BIT)) u_diag_monitor (
      .clk(clk), .line(pulse), .start(fs), .frame(frame), .done(done));
   task check(input string what, input logic [9:0] e, input logic [9:0] s);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : check
   task end_sim;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task wait_fs;
      i = 0;
      @(negedge clk);
      while (fs !== 1'b1 && i < 200) begin
         @(negedge clk);
         i++;
      end
      if (fs !== 1'b1) begin
         failures++;
         end_sim();
      end
   endtask : wait_fs
   // negedge, so the monitor's edge updates have landed
   always @(negedge clk) begin
      if (done === 1'b1) begin
         want = exp_q.size() ? exp_q.pop_front() : 10'h3ff;
         check("frame", want, frame);
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      #5;
      rstn = 1'b1;
      fl = 10'h200;
      // lower slots random after the first frame, so priority can be in play
      for (int k = 0; k < 12; k++) begin
         wait_fs();
         exp_q.push_back(tbl[cur]);
         repeat (1 + {$random(seed)} % 60) @(posedge clk);
         #5;
         if (cur > 0) cur--;
         rnd = 10'($random(seed));
         fl = (10'h001 << cur) | (rnd & (10'h3fe << cur));
      end
      for (i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk);
      if (exp_q.size() != 0) begin
         failures++;
         end_sim();
      end
      #5;
      rstn = 1'b0;
      fl = '0;
      repeat (4) @(posedge clk);
      #5;
      rstn = 1'b1;
      repeat (20) begin
         @(negedge clk);
         check("idle", 10'h000, {7'h00, pulse, fs, active});
      end
      // status frame whose flag drops mid-frame: it ends whole, then the line idles
      @(posedge clk);
      #5;
      fl = 10'h200;
      wait_fs();
      exp_q.push_back(tbl[9]);
      repeat (10) @(posedge clk);
      #5;
      fl = '0;
      for (i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk);
      if (exp_q.size() != 0) begin
         failures++;
         end_sim();
      end
      repeat (4) @(negedge clk);
      check("stop", 10'h000, {7'h00, pulse, fs, active});
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
